//--- logic/tsw_ram.v
`timescale 1ns/1ps
module tsw_ram #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire sys_clk_in,
	input wire rstn_in,
	input wire we_in,
	input wire [AW-1:0] addr_in,
	input wire [WIDTH-1:0] wdata_in,
	output reg [WIDTH-1:0] rdata_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	integer i;

	// Reset clears every entry, so connection memories start as unassigned.
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
			rdata_out <= {WIDTH{1'b0}};
		end else begin
			if (we_in) begin
				mem[addr_in] <= wdata_in;
			end
			rdata_out <= mem[addr_in];
		end
	end
endmodule // tsw_ram

//--- logic/tsw_regs.vh
`ifndef TSW_REGS_VH
`define TSW_REGS_VH

// Register byte offsets on the AXI4-Lite port.
`define TSW_OFF_DATA 8'h00
`define TSW_OFF_ADDR 8'h04
`define TSW_OFF_CTRL 8'h08
`define TSW_OFF_MODE 8'h0C
`define TSW_OFF_PBN 8'h10
`define TSW_OFF_STAT 8'h14

// Reset values.
`define TSW_RST_BYTE 8'h00
`define TSW_RST_MODE 2'h0

// Field positions.
`define TSW_BIT_DIR 7
`define TSW_BIT_BUSY 0
`define TSW_BIT_SYNC 1

// Operation and connection codes.
`define TSW_OP_CM 4'h7
`define TSW_OP_TRI 4'h6
`define TSW_CODE_NONE 4'h0
`define TSW_CODE_MAX 4'h7

// Reference clock phases (eight per timeslot).
`define TSW_PH_MEM_A 3'h0
`define TSW_PH_MEM_B 3'h4
`define TSW_PH_MEM_C 3'h7
`define TSW_PH_US_CM_E 3'h0
`define TSW_PH_US_WR_E 3'h1
`define TSW_PH_US_CM_O 3'h2
`define TSW_PH_US_WR_O 3'h3
`define TSW_PH_DS_CM_E 3'h3
`define TSW_PH_DS_CM_O 3'h4
`define TSW_PH_DS_RD_E 3'h5
`define TSW_PH_DS_RD_O 3'h6
`define TSW_PH_CPU_CM 3'h7
`define TSW_PH_CPU_TRI 3'h2
`define TSW_PH_LAST 3'h7

// Timing distances in timeslots.
`define TSW_CFI_LEAD_E 5'h03
`define TSW_CFI_LEAD_O 5'h04
`define TSW_US_BACK_E 5'h02
`define TSW_US_BACK_O 5'h01

// Bit-number values at or above this limit are invalid.
`define TSW_PBN_LIMIT 8'h08

`define TSW_RESP_OK 2'b00
`define TSW_RESP_ERR 2'b10

`endif

//--- logic/tsw_switch.v
// Contract
// - Codes 0001..0111 drive subscriber output; code 0000 keeps it disabled.
// - Upstream pointer msb zero loops internal downstream output into upstream input.
// - Tristate operation with nibble all ones drives every bit of PCM slot.
// - Each data memory holds just one frame; delay depends on slot positions.
// - Read after write gives this frame's data, otherwise previous frame's.
// - Data received in frame N leaves in frame N, N+1 or N+2.
// - Downstream PCM data written in phases 0, 4 and 7 per block.
// - Phase 0 at each downstream PCM block boundary is no write cycle.
// - Subscriber pair fetched in phases 5 and 6, three slots ahead.
// - Subscriber reads follow fixed port order per interface mode.
// - Upstream subscriber data written at even slots in phases 1 and 3.
// - PCM transmit block read in phases 0, 4, 7, ahead by 4/7/13.
// - Phase 0 at second, third or fifth slot of block is no read.
// - PCM transmit reads proceed in two steps per block.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tsw_regs.vh"
module tsw_switch (
	input wire sys_clk_in,
	input wire rstn_in,
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire frame_sync_in,
	input wire [7:0] pcm_receive_in,
	input wire [7:0] subscriber_upstream_input_in,
	output reg [7:0] pcm_transmit_output_out,
	output reg [7:0] pcm_transmit_oe_out,
	output reg [7:0] subscriber_downstream_output_out,
	output reg subscriber_downstream_oe_out,
	output reg [1:0] subscriber_port_out,
	output wire frame_sync_ok_out
);
	// Block length in timeslots for the PCM modes.
	function [4:0] tsw_blk;
		input [1:0] mode;
		begin
			case (mode)
				2'd0: tsw_blk = 5'd2;
				2'd1: tsw_blk = 5'd4;
				default: tsw_blk = 5'd8;
			endcase
		end
	endfunction

	// Slot within a block at which the transmit read of a later block starts.
	function [4:0] tsw_tx_start;
		input [1:0] mode;
		begin
			case (mode)
				2'd0: tsw_tx_start = 5'd0;
				2'd1: tsw_tx_start = 5'd1;
				default: tsw_tx_start = 5'd3;
			endcase
		end
	endfunction

	// Slot within a block whose phase 0 is lost to internal delay on reads.
	function [4:0] tsw_tx_skip;
		input [1:0] mode;
		begin
			case (mode)
				2'd0: tsw_tx_skip = 5'd1;
				2'd1: tsw_tx_skip = 5'd2;
				default: tsw_tx_skip = 5'd4;
			endcase
		end
	endfunction

	// Each tristate nibble bit enables one pair of transmit bits.
	function [7:0] tsw_expand;
		input [3:0] nib;
		begin
			tsw_expand = {{2{nib[3]}}, {2{nib[2]}}, {2{nib[1]}}, {2{nib[0]}}};
		end
	endfunction

	// Output port for the odd slot of a fetched pair.
	function [1:0] tsw_odd_port;
		input [1:0] mode;
		input [1:0] step;
		begin
			case (mode)
				2'd0: tsw_odd_port = step;
				2'd1: tsw_odd_port = 2'd1;
				default: tsw_odd_port = 2'd0;
			endcase
		end
	endfunction

	reg aw_have_q;
	reg w_have_q;
	reg [7:0] aw_addr_q;
	reg [7:0] w_data_q;
	reg w_strb_q;
	reg [7:0] memory_access_data_reg_q;
	reg [7:0] memory_access_address_reg_q;
	reg [7:0] memory_access_control_reg_q;
	reg [7:0] pcm_bit_number_reg_q;
	reg [1:0] pcm_mode_q;
	reg [1:0] cfi_mode_q;
	reg busy_q;
	reg sync_q;
	reg [2:0] ph_q;
	reg [4:0] ts_q;
	reg [7:0] ds_hold_q;
	reg [4:0] ds_hold_ts_q;
	reg ds_hold_v_q;
	reg [11:0] ds_ev_q;
	reg [11:0] ds_od_q;
	reg [1:0] step_q;
	reg [7:0] sbuf_data_q [0:3];
	reg [3:0] sbuf_code_q [0:3];
	reg [1:0] sbuf_port_q [0:3];
	reg [7:0] up_ext_q [0:1];
	reg [7:0] up_int_q [0:1];
	reg [3:0] rd_cnt_q;
	reg [4:0] rd_idx_q;
	reg rd_pend_q;
	reg [3:0] rd_pend_idx_q;
	reg [7:0] tx_data_q [0:15];
	reg [7:0] tx_oe_q [0:15];
	integer i;

	wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid_out;
	wire rd_go = s_axi_arvalid_in && !s_axi_rvalid_out;
	wire wr_byte = wr_go && w_strb_q;
	wire cpu_is_tri = memory_access_control_reg_q[7:4] == `TSW_OP_TRI;
	wire cpu_is_cm = memory_access_control_reg_q[7:4] == `TSW_OP_CM;
	wire cpu_up = memory_access_address_reg_q[`TSW_BIT_DIR];
	wire [4:0] cpu_slot = memory_access_address_reg_q[4:0];
	wire cpu_cm_go = busy_q && cpu_is_cm && ph_q == `TSW_PH_CPU_CM;
	wire cpu_tri_go = busy_q && cpu_is_tri && ph_q == `TSW_PH_CPU_TRI;
	wire cpu_done = busy_q && (cpu_is_tri ? ph_q == `TSW_PH_CPU_TRI : ph_q == `TSW_PH_CPU_CM);
	wire [7:0] pbn_wr = w_data_q;
	wire pbn_write = wr_byte && aw_addr_q == `TSW_OFF_PBN;
	wire [7:0] pbn_d = pbn_write ? pbn_wr : pcm_bit_number_reg_q;
	wire pbn_ok = pbn_d < `TSW_PBN_LIMIT;
	wire mem_ph = ph_q == `TSW_PH_MEM_A || ph_q == `TSW_PH_MEM_B || ph_q == `TSW_PH_MEM_C;
	wire [4:0] blk = tsw_blk(pcm_mode_q);
	wire [4:0] blk_pos = ts_q & (blk - 5'd1);
	wire ds_wr = ds_hold_v_q && mem_ph && !(ph_q == `TSW_PH_MEM_A && blk_pos == 5'd0);
	wire rd_start = ph_q == `TSW_PH_MEM_A && blk_pos == tsw_tx_start(pcm_mode_q);
	wire rd_cyc = mem_ph && !(ph_q == `TSW_PH_MEM_A && blk_pos == tsw_tx_skip(pcm_mode_q));
	wire us_rd = rd_cnt_q != 4'd0 && rd_cyc && !rd_start;
	wire [4:0] rd_base = ts_q - tsw_tx_start(pcm_mode_q) + {blk[3:0], 1'b0};
	wire ds_fetch = ts_q[0];
	wire us_even = !ts_q[0];
	wire [4:0] ts_e3 = ts_q + `TSW_CFI_LEAD_E;
	wire [4:0] ts_o4 = ts_q + `TSW_CFI_LEAD_O;
	wire [11:0] ds_cm_rd;
	wire [11:0] us_cm_rd;
	wire [7:0] ds_dm_rd;
	wire [7:0] us_dm_rd;
	wire [7:0] tri_rd;
	reg [4:0] ds_cm_addr;
	reg [4:0] us_cm_addr;
	reg [4:0] ds_dm_addr;
	wire us_wr_e = us_even && ph_q == `TSW_PH_US_WR_E;
	wire us_wr_o = us_even && ph_q == `TSW_PH_US_WR_O;
	wire us_loop = !us_cm_rd[`TSW_BIT_DIR];
	wire us_par = us_wr_o;
	wire us_wr = (us_wr_e || us_wr_o) && us_cm_rd[11:8] != `TSW_CODE_NONE;
	wire [7:0] us_byte = us_loop ? up_int_q[us_par] : up_ext_q[us_par];

	assign s_axi_awready_out = !aw_have_q;
	assign s_axi_wready_out = !w_have_q;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign frame_sync_ok_out = sync_q;

	// One memory entry per timeslot and direction: a single frame of buffering.
	always @* begin
		case (ph_q)
			`TSW_PH_DS_CM_E: ds_cm_addr = ts_e3;
			`TSW_PH_DS_CM_O: ds_cm_addr = ts_o4;
			default: ds_cm_addr = cpu_slot;
		endcase
		case (ph_q)
			`TSW_PH_US_CM_E: us_cm_addr = ts_q - `TSW_US_BACK_E;
			`TSW_PH_US_CM_O: us_cm_addr = ts_q - `TSW_US_BACK_O;
			default: us_cm_addr = cpu_slot;
		endcase
		if (ds_wr) begin
			ds_dm_addr = ds_hold_ts_q;
		end else if (ph_q == `TSW_PH_DS_RD_E) begin
			ds_dm_addr = ds_ev_q[4:0];
		end else begin
			ds_dm_addr = ds_od_q[4:0];
		end
	end

	tsw_ram #(.WIDTH(12), .DEPTH(32), .AW(5)) u_ds_cm (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.we_in(cpu_cm_go && !cpu_up),
		.addr_in(ds_cm_addr),
		.wdata_in({memory_access_control_reg_q[3:0], memory_access_data_reg_q}),
		.rdata_out(ds_cm_rd)
	);

	tsw_ram #(.WIDTH(12), .DEPTH(32), .AW(5)) u_us_cm (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.we_in(cpu_cm_go && cpu_up),
		.addr_in(us_cm_addr),
		.wdata_in({memory_access_control_reg_q[3:0], memory_access_data_reg_q}),
		.rdata_out(us_cm_rd)
	);

	tsw_ram #(.WIDTH(8), .DEPTH(32), .AW(5)) u_ds_dm (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.we_in(ds_wr),
		.addr_in(ds_dm_addr),
		.wdata_in(ds_hold_q),
		.rdata_out(ds_dm_rd)
	);

	tsw_ram #(.WIDTH(8), .DEPTH(32), .AW(5)) u_us_dm (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.we_in(us_wr),
		.addr_in(us_wr ? us_cm_rd[4:0] : rd_idx_q),
		.wdata_in(us_byte),
		.rdata_out(us_dm_rd)
	);

	tsw_ram #(.WIDTH(8), .DEPTH(32), .AW(5)) u_tri (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.we_in(cpu_tri_go),
		.addr_in(cpu_tri_go ? cpu_slot : rd_idx_q),
		.wdata_in(tsw_expand(memory_access_data_reg_q[3:0])),
		.rdata_out(tri_rd)
	);

	// Register bus: address and data are taken in either order.
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= `TSW_RST_BYTE;
			w_data_q <= `TSW_RST_BYTE;
			w_strb_q <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `TSW_RESP_OK;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rresp_out <= `TSW_RESP_OK;
			s_axi_rdata_out <= 32'h00000000;
		end else begin
			if (s_axi_awvalid_in && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr_in[7:2], 2'b00};
			end
			if (s_axi_wvalid_in && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata_in[7:0];
				w_strb_q <= s_axi_wstrb_in[0];
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= aw_addr_q > `TSW_OFF_STAT ? `TSW_RESP_ERR : `TSW_RESP_OK;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= `TSW_RESP_OK;
				case ({s_axi_araddr_in[7:2], 2'b00})
					`TSW_OFF_DATA: s_axi_rdata_out <= {24'h000000, memory_access_data_reg_q};
					`TSW_OFF_ADDR: s_axi_rdata_out <= {24'h000000, memory_access_address_reg_q};
					`TSW_OFF_CTRL: s_axi_rdata_out <= {24'h000000, memory_access_control_reg_q};
					`TSW_OFF_MODE: s_axi_rdata_out <= {28'h0000000, cfi_mode_q, pcm_mode_q};
					`TSW_OFF_PBN: s_axi_rdata_out <= {24'h000000, pcm_bit_number_reg_q};
					`TSW_OFF_STAT: s_axi_rdata_out <= {30'h00000000, sync_q, busy_q};
					default: begin
						s_axi_rdata_out <= 32'h00000000;
						s_axi_rresp_out <= `TSW_RESP_ERR;
					end
				endcase
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// Indirect memory access: writes wait for their free phase while busy.
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			memory_access_data_reg_q <= `TSW_RST_BYTE;
			memory_access_address_reg_q <= `TSW_RST_BYTE;
			memory_access_control_reg_q <= `TSW_RST_BYTE;
			pcm_bit_number_reg_q <= `TSW_RST_BYTE;
			pcm_mode_q <= `TSW_RST_MODE;
			cfi_mode_q <= `TSW_RST_MODE;
			busy_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			if (cpu_done) begin
				busy_q <= 1'b0;
			end
			if (wr_byte && !busy_q) begin
				case (aw_addr_q)
					`TSW_OFF_DATA: memory_access_data_reg_q <= w_data_q;
					`TSW_OFF_ADDR: memory_access_address_reg_q <= w_data_q;
					`TSW_OFF_CTRL: begin
						memory_access_control_reg_q <= w_data_q;
						busy_q <= 1'b1;
					end
					default: ;
				endcase
			end
			if (wr_byte && aw_addr_q == `TSW_OFF_MODE) begin
				pcm_mode_q <= w_data_q[1:0];
				cfi_mode_q <= w_data_q[3:2];
			end
			// A bit-number write drops sync; a frame pulse with a valid number, in the same or a later cycle, regains it.
			if (pbn_write) begin
				pcm_bit_number_reg_q <= w_data_q;
				sync_q <= 1'b0;
			end
			if (frame_sync_in && pbn_ok) begin
				sync_q <= 1'b1;
			end
		end
	end

	// Timeslot and phase counters; a new bit shift is applied only on resync.
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ph_q <= 3'h0;
			ts_q <= 5'h00;
		end else if (frame_sync_in && !sync_q && pbn_ok) begin
			ph_q <= pbn_d[2:0];
			ts_q <= 5'h00;
		end else begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == `TSW_PH_LAST) begin
				ts_q <= ts_q + 5'h01;
			end
		end
	end

	// Data paths use fixed phases; subscriber fetches run in odd slots and upstream writes in even slots.
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ds_hold_q <= `TSW_RST_BYTE;
			ds_hold_ts_q <= 5'h00;
			ds_hold_v_q <= 1'b0;
			ds_ev_q <= 12'h000;
			ds_od_q <= 12'h000;
			step_q <= 2'd0;
			rd_cnt_q <= 4'h0;
			rd_idx_q <= 5'h00;
			rd_pend_q <= 1'b0;
			rd_pend_idx_q <= 4'h0;
			pcm_transmit_output_out <= `TSW_RST_BYTE;
			pcm_transmit_oe_out <= `TSW_RST_BYTE;
			subscriber_downstream_output_out <= `TSW_RST_BYTE;
			subscriber_downstream_oe_out <= 1'b0;
			subscriber_port_out <= 2'd0;
			for (i = 0; i < 4; i = i + 1) begin
				sbuf_data_q[i] <= `TSW_RST_BYTE;
				sbuf_code_q[i] <= `TSW_CODE_NONE;
				sbuf_port_q[i] <= 2'd0;
			end
			for (i = 0; i < 2; i = i + 1) begin
				up_ext_q[i] <= `TSW_RST_BYTE;
				up_int_q[i] <= `TSW_RST_BYTE;
			end
			for (i = 0; i < 16; i = i + 1) begin
				tx_data_q[i] <= `TSW_RST_BYTE;
				tx_oe_q[i] <= `TSW_RST_BYTE;
			end
		end else begin
			// Downstream PCM capture; a fresh capture beats the write that empties the hold.
			if (ds_wr) begin
				ds_hold_v_q <= 1'b0;
			end
			if (ph_q == `TSW_PH_LAST) begin
				ds_hold_q <= pcm_receive_in;
				ds_hold_ts_q <= ts_q;
				ds_hold_v_q <= 1'b1;
				up_ext_q[ts_q[0]] <= subscriber_upstream_input_in;
				up_int_q[ts_q[0]] <= subscriber_downstream_output_out;
			end
			// Subscriber fetch of the pair three slots ahead, in port order.
			if (ds_fetch && ph_q == `TSW_PH_DS_CM_O) begin
				ds_ev_q <= ds_cm_rd;
			end
			if (ds_fetch && ph_q == `TSW_PH_DS_RD_E) begin
				ds_od_q <= ds_cm_rd;
			end
			if (ds_fetch && ph_q == `TSW_PH_DS_RD_O) begin
				sbuf_data_q[ts_e3[1:0]] <= ds_dm_rd;
				sbuf_code_q[ts_e3[1:0]] <= ds_ev_q[11:8];
				sbuf_port_q[ts_e3[1:0]] <= 2'd0;
			end
			if (ds_fetch && ph_q == `TSW_PH_LAST) begin
				sbuf_data_q[ts_o4[1:0]] <= ds_dm_rd;
				sbuf_code_q[ts_o4[1:0]] <= ds_od_q[11:8];
				sbuf_port_q[ts_o4[1:0]] <= tsw_odd_port(cfi_mode_q, step_q);
				step_q <= step_q + 2'd1;
			end
			// PCM transmit block read, first step then second step of the block.
			if (rd_start) begin
				rd_cnt_q <= blk[3:0];
				rd_idx_q <= rd_base;
			end else if (us_rd) begin
				rd_cnt_q <= rd_cnt_q - 4'h1;
				rd_idx_q <= rd_idx_q + 5'h01;
			end
			rd_pend_q <= us_rd;
			rd_pend_idx_q <= rd_idx_q[3:0];
			if (rd_pend_q) begin
				tx_data_q[rd_pend_idx_q] <= us_dm_rd;
				tx_oe_q[rd_pend_idx_q] <= tri_rd;
			end
			// Output registers load at the start of every slot.
			if (ph_q == `TSW_PH_LAST) begin
				pcm_transmit_output_out <= tx_data_q[ts_q[3:0] + 4'h1];
				pcm_transmit_oe_out <= tx_oe_q[ts_q[3:0] + 4'h1];
				subscriber_downstream_output_out <= sbuf_data_q[ts_q[1:0] + 2'd1];
				subscriber_port_out <= sbuf_port_q[ts_q[1:0] + 2'd1];
				subscriber_downstream_oe_out <= sbuf_code_q[ts_q[1:0] + 2'd1] != `TSW_CODE_NONE
					&& sbuf_code_q[ts_q[1:0] + 2'd1] <= `TSW_CODE_MAX;
			end
		end
	end
endmodule // tsw_switch

//--- testbench/tb_tdm_switch_loop_and_delay.sv
`timescale 1ns/1ps
module tb_tdm_switch_loop_and_delay;
	logic sys_clk_in = 0;
	logic rstn_in = 0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
	logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
	wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	wire s_axi_rvalid_out, subscriber_downstream_oe_out, frame_sync_ok_out, frame_sync_in;
	wire [1:0] s_axi_bresp_out, s_axi_rresp_out, subscriber_port_out;
	wire [31:0] s_axi_rdata_out;
	wire [7:0] pcm_receive_in, subscriber_upstream_input_in, pcm_transmit_output_out;
	wire [7:0] pcm_transmit_oe_out, subscriber_downstream_output_out;
	wire [2:0] frame_num;
	int err_count = 0, num_checks = 0, cycles = 0;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [7:0] po, pd, sd;
	logic so;
	logic [2:0] sf;
	logic [1:0] sp;
	tsw_switch uut (.sys_clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.frame_sync_in, .pcm_receive_in, .subscriber_upstream_input_in, .pcm_transmit_output_out,
		.pcm_transmit_oe_out, .subscriber_downstream_output_out, .subscriber_downstream_oe_out,
		.subscriber_port_out, .frame_sync_ok_out);
	tsw_highway_model hw (.sys_clk_in, .rstn_in, .frame_sync_out(frame_sync_in),
		.pcm_byte_out(pcm_receive_in), .sub_byte_out(subscriber_upstream_input_in),
		.frame_num_out(frame_num));
	always #12.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
			err_count++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1;
		s_axi_wvalid_in <= 1;
		s_axi_bready_in <= 1;
		aw = 1;
		w = 1;
		while (aw || w) begin
			@(posedge sys_clk_in);
			if (s_axi_awready_out === 1'b1) aw = 0;
			if (s_axi_wready_out === 1'b1) w = 0;
			s_axi_awvalid_in <= aw;
			s_axi_wvalid_in <= w;
		end
		do @(posedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
		rsp = s_axi_bresp_out;
		s_axi_bready_in <= 0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1;
		s_axi_rready_in <= 1;
		do @(posedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 0;
		do @(posedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
		rd = s_axi_rdata_out;
		rsp = s_axi_rresp_out;
		s_axi_rready_in <= 0;
	endtask
	// Writes to data and address are ignored while busy, so wait for busy to clear.
	task mem_op(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c);
		wr(8'h00, {24'h0, d});
		wr(8'h04, {24'h0, a});
		wr(8'h08, {24'h0, c});
		do rd_reg(8'h14); while (rd[0] !== 1'b0);
	endtask
	// Lets the new setting settle, then watches one whole frame.
	task scan;
		repeat (800) @(posedge sys_clk_in);
		po = 0;
		so = 0;
		pd = 0;
		sd = 0;
		sf = 0;
		sp = 0;
		repeat (256) begin
			@(posedge sys_clk_in);
			po = po | pcm_transmit_oe_out;
			so = so | subscriber_downstream_oe_out;
			if (pcm_transmit_oe_out === 8'hFF) pd = pcm_transmit_output_out;
			if (subscriber_downstream_oe_out === 1'b1) sd = subscriber_downstream_output_out;
			if (subscriber_downstream_oe_out === 1'b1) sf = frame_num - sd[7:5];
			if (subscriber_downstream_oe_out === 1'b1) sp = subscriber_port_out;
		end
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_in);
		rstn_in <= 1;
		for (int i = 0; i < 5; i++) begin
			rd_reg(8'(4 * i));
			chk(rd, 32'h0);
			chk(rsp, 2'b00);
		end
		rd_reg(8'h18);
		chk(rd, 32'h0);
		chk(rsp, 2'b10);
		wr(8'h18, 32'h5A);
		chk(rsp, 2'b10);
		wr(8'h0C, 32'h01);
		rd_reg(8'h0C);
		chk(rd, 32'h01);
		$display("test registers done");
		scan;
		chk(po, 8'h00);
		mem_op(8'h05, 8'h85, 8'h60);
		scan;
		chk(po, 8'h33);
		mem_op(8'h0F, 8'h85, 8'h60);
		scan;
		chk(po, 8'hFF);
		$display("test tristate done");
		for (int c = 7; c >= 0; c--) begin
			mem_op(8'h0D, 8'h04, 8'(8'h70 + c));
			scan;
			chk(so, c != 0);
			if (c != 0) chk(sd[4:0], 5'd13);
			if (c != 0) chk(sf >= 3'd1 && sf <= 3'd2, 1'b1);
		end
		// Odd slot 7 is the second odd slot of the port cycle, so it leaves on port 1.
		mem_op(8'h0D, 8'h07, 8'h71);
		scan;
		chk(sp, 2'd1);
		chk(sd[4:0], 5'd13);
		wr(8'h0C, 32'h09);
		scan;
		chk(sp, 2'd0);
		$display("test codes and delay done");
		mem_op(8'h05, 8'h84, 8'h71);
		scan;
		chk(pd[4:0], 5'd13);
		mem_op(8'h85, 8'h84, 8'h71);
		scan;
		chk(pd[4:0], 5'd4);
		$display("test pcm loop done");
		wr(8'h10, 32'h08);
		scan;
		rd_reg(8'h14);
		chk({rd[1], frame_sync_ok_out}, 2'b00);
		wr(8'h10, 32'h00);
		scan;
		rd_reg(8'h14);
		chk({rd[1], frame_sync_ok_out}, 2'b11);
		$display("test resync done");
		end_sim;
	end
endmodule // tb_tdm_switch_loop_and_delay

//--- testbench/tsw_highway_model.sv
`timescale 1ns/1ps
module tsw_highway_model (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	output logic frame_sync_out,
	output logic [7:0] pcm_byte_out,
	output logic [7:0] sub_byte_out,
	output logic [2:0] frame_num_out
);
	logic [7:0] cnt_q;
	always @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			cnt_q <= 8'h00;
			frame_num_out <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == 8'hFF)
				frame_num_out <= frame_num_out + 3'h1;
		end
	end
	// The pulse sits in the last cycle so the switch starts phase 0 with slot 0.
	assign frame_sync_out = rstn_in && cnt_q == 8'hFF;
	// Each byte names its slot and frame, so outputs reveal source slot and delay.
	assign pcm_byte_out = {frame_num_out, cnt_q[7:3]};
	assign sub_byte_out = {frame_num_out, cnt_q[7:3]};
endmodule // tsw_highway_model

//--- testbench/tsw_switch_asserts.sv
`timescale 1ns/1ps
module tsw_switch_asserts (
	input logic sys_clk_in,
	input logic rstn_in,
	input logic [7:0] s_axi_awaddr_in,
	input logic s_axi_awvalid_in,
	input logic s_axi_awready_out,
	input logic [31:0] s_axi_wdata_in,
	input logic [3:0] s_axi_wstrb_in,
	input logic s_axi_wvalid_in,
	input logic s_axi_wready_out,
	input logic [1:0] s_axi_bresp_out,
	input logic s_axi_bvalid_out,
	input logic s_axi_bready_in,
	input logic [7:0] s_axi_araddr_in,
	input logic s_axi_arvalid_in,
	input logic s_axi_arready_out,
	input logic [31:0] s_axi_rdata_out,
	input logic [1:0] s_axi_rresp_out,
	input logic s_axi_rvalid_out,
	input logic s_axi_rready_in,
	input logic [7:0] pcm_transmit_oe_out,
	input logic subscriber_downstream_oe_out,
	input logic frame_sync_ok_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	wire wr_hs = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
	wire rd_hs = s_axi_arvalid_in & s_axi_arready_out;
	a_read_latency: assert property (rd_hs |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
	a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
	a_write_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer late");
	a_unmapped_read: assert property (rd_hs && s_axi_araddr_in[7:2] > 6'h05
		|=> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0) else $error("bad unmapped read");
	a_unmapped_write: assert property (wr_hs && s_axi_awaddr_in[7:2] > 6'h05
		|-> ##[1:2] (s_axi_bvalid_out && s_axi_bresp_out == 2'b10)) else $error("bad unmapped write");
	a_no_new_aw: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
		else $error("second address taken while one held");
	a_no_new_ar: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken during answer");
	a_upper_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	a_reset_quiet: assert property ($rose(rstn_in) |-> pcm_transmit_oe_out == 8'h00
		&& !subscriber_downstream_oe_out && !frame_sync_ok_out) else $error("outputs after reset");
	a_bad_bitnum: assert property (wr_hs && s_axi_awaddr_in == 8'h10
		&& s_axi_wstrb_in[0] && s_axi_wdata_in[7:0] >= 8'h08 |-> ##3 !frame_sync_ok_out)
		else $error("sync kept after invalid bit number");
	cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
	cover property ($rose(frame_sync_ok_out));
	cover property (pcm_transmit_oe_out == 8'hFF);
	cover property (subscriber_downstream_oe_out);
endmodule // tsw_switch_asserts
bind tsw_switch tsw_switch_asserts u_asserts (.sys_clk_in, .rstn_in, .s_axi_awaddr_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .pcm_transmit_oe_out, .subscriber_downstream_oe_out, .frame_sync_ok_out);
